/* File: hw/gipr_pkg.sv */
// constants and types shared by the interrupt pin router
package gipr_pkg;
    // ***********************************************
    // register map
    // ***********************************************
    localparam logic [7:0] GIPR_ADDR_PIN_CONTROL = 8'h14;
    localparam logic [7:0] GIPR_ADDR_SOURCE_FLAGS = 8'h0b;
    localparam logic [7:0] GIPR_ADDR_THRESHOLD_SOURCE = 8'h0e;
    localparam logic [7:0] GIPR_PIN_CONTROL_RESET = 8'h00;

    // ***********************************************
    // field positions of interrupt_pin_control
    // ***********************************************
    localparam int GIPR_BIT_FIFO_ROUTE = 7;
    localparam int GIPR_BIT_FIFO_ENABLE = 6;
    localparam int GIPR_BIT_THRESHOLD_ROUTE = 5;
    localparam int GIPR_BIT_THRESHOLD_ENABLE = 4;
    localparam int GIPR_BIT_SAMPLE_ROUTE = 3;
    localparam int GIPR_BIT_SAMPLE_ENABLE = 2;
    localparam int GIPR_BIT_POLARITY = 1;
    localparam int GIPR_BIT_DRIVER_TYPE = 0;

    // ***********************************************
    // source flag register layout and flag indices
    // ***********************************************
    localparam int GIPR_SRC_SAMPLE = 0;
    localparam int GIPR_SRC_THRESHOLD = 1;
    localparam int GIPR_SRC_FIFO = 2;
    localparam int GIPR_NUM_SOURCES = 3;

    typedef enum logic [1:0] {
        GIPR_BUS_IDLE = 2'b00,
        GIPR_BUS_ACCESS = 2'b01,
        GIPR_BUS_DONE = 2'b11
    } gipr_bus_state_type;
endpackage

/* File: hw/gipr_pin_if.sv */
// bundle between the router core and one pin driver
`timescale 1ns/1ps
`default_nettype none
interface gipr_pin_if;
    logic assert_req;
    logic polarity;
    logic open_drain;
    logic pin_out;
    logic pin_oe_n;
    modport core (output assert_req, output polarity, output open_drain,
                  input pin_out, input pin_oe_n);
    modport drv (input assert_req, input polarity, input open_drain,
                 output pin_out, output pin_oe_n);
endinterface
`default_nettype wire

/* File: hw/gipr_pin_driver.sv */
// registered output stage of one interrupt pin
`timescale 1ns/1ps
`default_nettype none
module gipr_pin_driver (
    input wire logic clk_i,
    input wire logic rst_n_i,
    gipr_pin_if.drv pin
);
    import gipr_pkg::*;

    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
    } gipr_drv_state_type;

    gipr_drv_state_type state_reg;
    gipr_drv_state_type state_next;

    // asserted level follows polarity; released only when open drain and idle
    always_comb begin
        state_next = state_reg;
        if (pin.assert_req) begin
            state_next.pin_out = pin.polarity; // [R8] [R10]
            state_next.pin_oe_n = 1'b0;
        end else if (pin.open_drain) begin
            state_next.pin_out = pin.polarity; // [R9] [R10]
            state_next.pin_oe_n = 1'b1; // [R10]
        end else begin
            state_next.pin_out = ~pin.polarity; // [R8] [R9]
            state_next.pin_oe_n = 1'b0;
        end
    end

    // after reset: active low, push-pull, deasserted => driven high
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= '{pin_out: 1'b1, pin_oe_n: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin.pin_out = state_reg.pin_out;
    assign pin.pin_oe_n = state_reg.pin_oe_n;
endmodule
`default_nettype wire

/* File: hw/gipr_router.sv */
// interrupt control register, source flags and pin routing of the rate sensor
// How it works
// [R1] one 8-bit control register at 0x14 holds enables, routes, polarity, driver
// [R2] bit 7 routes fifo interrupt: 1 first pin, 0 second pin
// [R3] bit 6 enables fifo interrupt onto its routed pin
// [R4] bit 5 routes threshold interrupt: 1 first pin, 0 second pin
// [R5] bit 4 enables threshold interrupt onto its routed pin
// [R6] bit 3 routes sample-ready interrupt: 1 first pin, 0 second pin
// [R7] bit 2 enables sample-ready interrupt onto its routed pin
// [R8] bit 1 polarity: 0 active low, 1 active high; push-pull drives opposite
// [R9] bit 0 driver: 0 push-pull, 1 open-drain for both pins
// [R10] open-drain drives active level when asserted, releases when deasserted
// [R11] board adds pull-up for active low, pull-down for active high
// [R12] reading threshold source register clears threshold flag at 0x0b
// [R13] pin asserts while any enabled routed flag set; control resets to zero
`timescale 1ns/1ps
`default_nettype none
module gipr_router (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic fifo_event_i,
    input wire logic threshold_event_i,
    input wire logic threshold_level_i,
    input wire logic sample_ready_event_i,
    input wire logic fifo_level_i,
    input wire logic sample_ready_clear_i,
    output logic irq_pin_first_o,
    output logic irq_pin_first_oe_n_o,
    output logic irq_pin_second_o,
    output logic irq_pin_second_oe_n_o
);
    import gipr_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    typedef struct packed {
        logic [7:0] interrupt_pin_control;
        logic [GIPR_NUM_SOURCES-1:0] flags;
        logic [7:0] rdata;
        logic ack;
    } gipr_state_type;

    gipr_state_type state_reg;
    gipr_state_type state_next;

    logic [GIPR_NUM_SOURCES-1:0] enable;
    logic [GIPR_NUM_SOURCES-1:0] route_first;
    logic [GIPR_NUM_SOURCES-1:0] active;
    logic [GIPR_NUM_SOURCES-1:0] set_ev;

    gipr_pin_if pin_first ();
    gipr_pin_if pin_second ();

    // ***********************************************
    // field decode
    // ***********************************************
    assign enable[GIPR_SRC_FIFO] = state_reg.interrupt_pin_control[GIPR_BIT_FIFO_ENABLE]; // [R3]
    assign route_first[GIPR_SRC_FIFO] =
        state_reg.interrupt_pin_control[GIPR_BIT_FIFO_ROUTE]; // [R2]
    assign enable[GIPR_SRC_THRESHOLD] =
        state_reg.interrupt_pin_control[GIPR_BIT_THRESHOLD_ENABLE]; // [R5]
    assign route_first[GIPR_SRC_THRESHOLD] =
        state_reg.interrupt_pin_control[GIPR_BIT_THRESHOLD_ROUTE]; // [R4]
    assign enable[GIPR_SRC_SAMPLE] =
        state_reg.interrupt_pin_control[GIPR_BIT_SAMPLE_ENABLE]; // [R7]
    assign route_first[GIPR_SRC_SAMPLE] =
        state_reg.interrupt_pin_control[GIPR_BIT_SAMPLE_ROUTE]; // [R6]

    // event pulses from the source logic, same clock
    assign set_ev[GIPR_SRC_FIFO] = fifo_event_i;
    assign set_ev[GIPR_SRC_THRESHOLD] = threshold_event_i;
    assign set_ev[GIPR_SRC_SAMPLE] = sample_ready_event_i;

    // disabled sources never reach a pin, even with their flag set
    assign active = state_reg.flags & enable; // [R3] [R5] [R7]

    // ***********************************************
    // next state
    // ***********************************************
    always_comb begin
        state_next = state_reg;
        state_next.ack = reg_wr_i | reg_rd_i;
        state_next.rdata = 8'h00;
        if (reg_wr_i && reg_addr_i == GIPR_ADDR_PIN_CONTROL) begin
            state_next.interrupt_pin_control = reg_wdata_i; // [R1]
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                GIPR_ADDR_PIN_CONTROL: state_next.rdata = state_reg.interrupt_pin_control; // [R1]
                GIPR_ADDR_SOURCE_FLAGS: state_next.rdata = {5'h00, state_reg.flags};
                default: state_next.rdata = 8'h00;
            endcase
        end
        // threshold flag cleared by a read of its source register
        if (reg_rd_i && reg_addr_i == GIPR_ADDR_THRESHOLD_SOURCE) begin
            state_next.flags[GIPR_SRC_THRESHOLD] = 1'b0; // [R12]
        end
        // fifo flag follows fifo_level_i; the sample flag holds until its owner raises sample_ready_clear_i
        state_next.flags[GIPR_SRC_FIFO] = fifo_level_i;
        if (sample_ready_clear_i) begin
            state_next.flags[GIPR_SRC_SAMPLE] = 1'b0;
        end
        // a level held by the threshold logic keeps the flag, set wins over clear
        state_next.flags = state_next.flags | set_ev
            | {1'b0, threshold_level_i, 1'b0}; // [R12] [R13]
    end

    // synchronous reset: control register and flags all zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= '{interrupt_pin_control: GIPR_PIN_CONTROL_RESET, // [R13]
                           flags: '0, rdata: 8'h00, ack: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ***********************************************
    // pin routing
    // ***********************************************
    // or of every enabled flag routed to each pin
    assign pin_first.assert_req = |(active & route_first); // [R13] [R2] [R4] [R6]
    assign pin_second.assert_req = |(active & ~route_first); // [R13]
    assign pin_first.polarity = state_reg.interrupt_pin_control[GIPR_BIT_POLARITY]; // [R8]
    assign pin_second.polarity = state_reg.interrupt_pin_control[GIPR_BIT_POLARITY];
    assign pin_first.open_drain = state_reg.interrupt_pin_control[GIPR_BIT_DRIVER_TYPE]; // [R9]
    assign pin_second.open_drain = state_reg.interrupt_pin_control[GIPR_BIT_DRIVER_TYPE];

    // open-drain released level relies on the board resistor [R11]
    gipr_pin_driver u_drv_first (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin(pin_first.drv)
    );
    gipr_pin_driver u_drv_second (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin(pin_second.drv)
    );

    assign irq_pin_first_o = pin_first.pin_out;
    assign irq_pin_first_oe_n_o = pin_first.pin_oe_n;
    assign irq_pin_second_o = pin_second.pin_out;
    assign irq_pin_second_oe_n_o = pin_second.pin_oe_n;
    assign reg_rdata_o = state_reg.rdata;
    assign reg_ack_o = state_reg.ack;
endmodule
`default_nettype wire

/* File: verif/gipr_host_model.sv */
// host interrupt input line with its board pull resistor
`timescale 1ns/1ps
`default_nettype none
module gipr_host_model (
    input wire logic pin_i,
    input wire logic oe_n_i,
    input wire logic pull_up_i,
    output logic line_o
);
    // a released pin settles at the resistor level, never at its last driven value
    assign line_o = oe_n_i ? pull_up_i : pin_i;
endmodule
`default_nettype wire

/* File: verif/gipr_router_asserts.sv */
// concurrent checks on the ports of the interrupt pin router
`timescale 1ns/1ps
`default_nettype none
module gipr_router_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic fifo_event_i,
    input wire logic threshold_event_i,
    input wire logic irq_pin_first_o,
    input wire logic irq_pin_first_oe_n_o,
    input wire logic irq_pin_second_o,
    input wire logic irq_pin_second_oe_n_o
);
    logic [7:0] ctrl_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the control byte: pin checks need it but it has no port
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) ctrl_reg <= 8'h00;
        else if (reg_wr_i && reg_addr_i == 8'h14) ctrl_reg <= reg_wdata_i;
    end
    sequence s_settled;
        $stable(ctrl_reg)[*2];
    endsequence
    sequence s_thr;
        s_settled ##0 (ctrl_reg[5:4] == 2'b11 && threshold_event_i) ##1 $stable(ctrl_reg)[*2];
    endsequence
    sequence s_fifo;
        s_settled ##0 (ctrl_reg[7:6] == 2'b11 && fifo_event_i) ##1 $stable(ctrl_reg)[*2];
    endsequence
    property p_ack; (reg_wr_i || reg_rd_i) |=> reg_ack_o; endproperty
    property p_no_ack; !(reg_wr_i || reg_rd_i) |=> !reg_ack_o; endproperty
    property p_rd_idle; !reg_ack_o |-> reg_rdata_o == 8'h00; endproperty
    property p_rd_ctrl;
        reg_rd_i && !reg_wr_i && reg_addr_i == 8'h14 |=> reg_rdata_o == $past(ctrl_reg);
    endproperty
    property p_rd_other;
        reg_rd_i && reg_addr_i != 8'h14 && reg_addr_i != 8'h0b |=> reg_rdata_o == 8'h00;
    endproperty
    // with every source gated off both pins sit at their deasserted state
    property p_idle;
        s_settled ##0 (ctrl_reg & 8'h54) == 8'h00 |-> irq_pin_first_oe_n_o == ctrl_reg[0]
            && irq_pin_second_oe_n_o == ctrl_reg[0] && (ctrl_reg[0]
            || (irq_pin_first_o != ctrl_reg[1] && irq_pin_second_o != ctrl_reg[1]));
    endproperty
    property p_thr; s_thr |-> irq_pin_first_o == ctrl_reg[1] && !irq_pin_first_oe_n_o; endproperty
    property p_fifo; s_fifo |-> irq_pin_first_o == ctrl_reg[1] && !irq_pin_first_oe_n_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after strobe");
    a_no_ack: assert property (p_no_ack) else $error("ack without strobe");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
    a_rd_other: assert property (p_rd_other) else $error("unmapped read not zero");
    a_idle: assert property (p_idle) else $error("idle pin state wrong");
    a_thr: assert property (p_thr) else $error("threshold pin not asserted");
    a_fifo: assert property (p_fifo) else $error("fifo pin not asserted");
endmodule
bind gipr_router gipr_router_asserts CHK (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .fifo_event_i(fifo_event_i),
    .threshold_event_i(threshold_event_i), .irq_pin_first_o(irq_pin_first_o),
    .irq_pin_first_oe_n_o(irq_pin_first_oe_n_o), .irq_pin_second_o(irq_pin_second_o),
    .irq_pin_second_oe_n_o(irq_pin_second_oe_n_o));
`default_nettype wire

/* File: verif/gyro_interrupt_pin_router_tb_top.sv */
// self-checking bench of the interrupt pin router
`timescale 1ns/1ps
`default_nettype none
module gyro_interrupt_pin_router_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr = 1'b0, rd = 1'b0, sclr = 1'b0, pol = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [2:0] ev = 3'b000;
    logic lvl_t = 1'b0, lvl_f = 1'b0;
    logic ack, p1, p1_oe_n, p2, p2_oe_n, line1, line2;
    int fail_count = 0, n_checks = 0, cyc = 0;
    always #10 clk_i = ~clk_i;
    gipr_router DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_ack_o(ack),
        .fifo_event_i(ev[2]), .threshold_event_i(ev[1]), .threshold_level_i(lvl_t),
        .sample_ready_event_i(ev[0]), .fifo_level_i(lvl_f), .sample_ready_clear_i(sclr),
        .irq_pin_first_o(p1), .irq_pin_first_oe_n_o(p1_oe_n), .irq_pin_second_o(p2),
        .irq_pin_second_oe_n_o(p2_oe_n));
    // board pull opposes the active level so a released line reads deasserted
    gipr_host_model HOST1 (.pin_i(p1), .oe_n_i(p1_oe_n), .pull_up_i(!pol), .line_o(line1));
    gipr_host_model HOST2 (.pin_i(p2), .oe_n_i(p2_oe_n), .pull_up_i(!pol), .line_o(line2));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one strobe cycle; returns just after the edge that carries the ack
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    // event pulse, then wait for the pin stage two edges later
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_i) ev <= m;
        @(posedge clk_i) ev <= 3'b000;
        @(posedge clk_i) #1;
    endtask
    task automatic clear_all();
        @(posedge clk_i) sclr <= 1'b1;
        @(posedge clk_i) sclr <= 1'b0;
        acc(1'b0, 8'h0e, 8'h00);
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        acc(1'b0, 8'h14, 8'h00); chk(rdata, 8'h00);
        acc(1'b1, 8'h14, 8'ha5);
        acc(1'b1, 8'h33, 8'hff);
        acc(1'b0, 8'h14, 8'h00); chk(rdata, 8'ha5);
        acc(1'b0, 8'h33, 8'h00); chk(rdata, 8'h00);
        acc(1'b1, 8'h14, 8'h00);
    endtask
    // every polarity and driver pairing, threshold set then cleared by a read
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            pol <= m[1];
            acc(1'b1, 8'h14, 8'h30 | 8'(m));
            @(posedge clk_i) #1;
            chk({line1, line2, p1_oe_n}, {!pol, !pol, m[0]});
            pulse(3'b010);
            chk({line1, p1_oe_n, line2}, {pol, 1'b0, !pol});
            acc(1'b0, 8'h0b, 8'h00); chk(rdata, 8'h02);
            acc(1'b0, 8'h0e, 8'h00); chk(rdata, 8'h00);
            acc(1'b0, 8'h0b, 8'h00); chk({rdata, line1}, {8'h00, !pol});
        end
    endtask
    // each source gated off, then routed to either pin, active high push-pull
    task automatic t_route();
        logic [7:0] c;
        pol <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            for (int r = 0; r < 2; r++) begin
                c = 8'h02 | (8'(r) << (3 + 2 * s));
                acc(1'b1, 8'h14, c);
                pulse(3'b001 << s);
                chk({p1, p2}, 2'b00);
                clear_all();
                acc(1'b1, 8'h14, c | (8'h01 << (2 + 2 * s)));
                pulse(3'b001 << s);
                chk({p1, p2}, {r[0], !r[0]});
                clear_all();
                chk({p1, p2}, 2'b00);
            end
        end
    endtask
    // level-held sources: a threshold level survives the clearing read, fifo follows its level
    task automatic t_levels();
        acc(1'b1, 8'h14, 8'h12);
        @(posedge clk_i) lvl_t <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk({p1, p2}, 2'b01);
        acc(1'b0, 8'h0e, 8'h00);
        @(posedge clk_i) #1;
        chk({p1, p2}, 2'b01);
        @(posedge clk_i) lvl_t <= 1'b0;
        acc(1'b0, 8'h0e, 8'h00);
        @(posedge clk_i) #1;
        chk({p1, p2}, 2'b00);
        acc(1'b1, 8'h14, 8'hc2);
        @(posedge clk_i) lvl_f <= 1'b1;
        acc(1'b0, 8'h0b, 8'h00);
        chk({rdata, p1, p2}, {8'h04, 1'b1, 1'b0});
        @(posedge clk_i) lvl_f <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({p1, p2}, 2'b00);
    endtask
    // cut a hang short well beyond the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_modes();
        t_route();
        t_levels();
        tally_and_finish();
    end
endmodule
`default_nettype wire
